// ===== include/cct_pkg.sv
// package: register map, field layout and types of the capture/compare timer
package cct_pkg;
  // counter and prescaler widths, channel count
  localparam int unsigned CNT_W   = 16;
  localparam int unsigned DIV_W   = 6;
  localparam int unsigned NCH     = 4;
  // register byte offsets
  localparam logic [7:0]  OFS_SC  = 8'h00;  // status and control
  localparam logic [7:0]  OFS_CNT = 8'h04;  // counter, read only
  localparam logic [7:0]  OFS_MOD = 8'h08;  // period limit high:low
  localparam logic [2:0]  CH_PAGE = 3'h1;   // paddr[7:5] of channel block 0x20..0x3C
  localparam int unsigned CH_IDX_LSB = 3;   // paddr[4:3] picks the channel
  localparam int unsigned CH_VAL_BIT = 2;   // paddr[2]: 0 control, 1 value
  // status and control fields
  localparam int unsigned SC_FLAG = 7;      // overflow_flag
  localparam int unsigned SC_IE   = 6;      // overflow_irq_enable
  localparam int unsigned SC_STOP = 5;      // counter stop
  localparam int unsigned SC_RST  = 4;      // counter reset, write one, reads zero
  localparam int unsigned SEL_MSB = 2;      // clock_select_field [2:0]
  localparam int unsigned CH_FLAG = 7;      // channel_event_flag in channel control
  // values after reset
  localparam logic             STOP_RST = 1'h1;
  localparam logic [2:0]       SEL_RST  = 3'h0;
  localparam logic [CNT_W-1:0] MOD_RST  = 16'hFFFF;
  localparam logic [CNT_W-1:0] VAL_RST  = 16'h0000;
  localparam logic [2:0]       SEL_EXT  = 3'h7;  // external clock pin
  // compare action codes; capture uses bit0 rising, bit1 falling
  typedef enum logic [1:0] {
    ACT_NONE   = 2'h0,
    ACT_TOGGLE = 2'h1,
    ACT_CLEAR  = 2'h2,
    ACT_SET    = 2'h3
  } cct_act_e;
  // channel control register, one byte
  typedef struct packed {
    logic       flag;  // channel_event_flag
    logic       ie;    // channel_irq_enable
    logic       buf_;  // pair buffer select, even channels only
    logic       oc;    // 1 output compare, 0 input capture
    logic [1:0] el;    // edge select or compare action
    logic       tov;   // toggle_on_wrap
    logic       maxd;  // full_duty_select
  } cct_chctl_s;
  localparam cct_chctl_s CTL_RST = 8'h00;
endpackage

// ===== src/cct_chan.sv
// one capture/compare channel: edge detect, compare match and pin driver
`timescale 1ns/1ps
module cct_chan #(
  parameter int unsigned CW = cct_pkg::CNT_W
) (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire cct_pkg::cct_chctl_s ctl,      // effective control
  input  wire logic               en,       // channel owns its pin
  input  wire logic               adv,      // counter advances this cycle
  input  wire logic               wrap,     // counter wraps this cycle
  input  wire logic [CW-1:0]      cnt_nx,   // counter value after this cycle
  input  wire logic [CW-1:0]      cmp_val,  // active compare value
  input  wire logic               pin_in,
  output logic                    cap_ev,   // capture event, comb pulse
  output logic                    cmp_ev,   // compare event, comb pulse
  output logic                    pin_out,
  output logic                    pin_oe
);
  logic prev_q;      // pin level last cycle
  logic pin_q;       // output level
  logic oe_q;        // drive enable
  logic is_oc;       // channel drives its pin
  logic hold_full;   // full duty hold, compares do not move the pin

  always_comb begin
    is_oc = en & ctl.oc;
    hold_full = is_oc & ctl.maxd & ~ctl.tov;
    // RULE_07 edge polarity select
    cap_ev = en & ~ctl.oc & ((ctl.el[0] & pin_in & ~prev_q) | (ctl.el[1] & ~pin_in & prev_q));
    // RULE_21 match when counter reaches value
    cmp_ev = is_oc & adv & (cnt_nx == cmp_val);
  end

  // pin history for edge detection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_q <= 1'h0;
    end else begin
      prev_q <= pin_in;
    end
  end

  // pin driver; compare action beats the wrap toggle, so a zero value gives no pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_q <= 1'h0;
      oe_q  <= 1'h0;
    end else begin
      oe_q <= is_oc;
      // RULE_25 full duty holds pulse level
      if (hold_full && wrap) begin
        pin_q <= (ctl.el != cct_pkg::ACT_SET);
      end else if (cmp_ev && !hold_full) begin
        // RULE_09 set, clear or toggle
        case (ctl.el)
          cct_pkg::ACT_TOGGLE: pin_q <= ~pin_q;
          cct_pkg::ACT_CLEAR:  pin_q <= 1'h0;
          cct_pkg::ACT_SET:    pin_q <= 1'h1;
          default:             pin_q <= pin_q;
        endcase
      end else if (is_oc && wrap && ctl.tov) begin
        // RULE_18 toggle at wrap
        pin_q <= ~pin_q;
      end
    end
  end

  assign pin_out = pin_q;
  assign pin_oe  = oe_q;

  pin_set_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_09
    cmp_ev && !hold_full && ctl.el == cct_pkg::ACT_SET |=> pin_out)
    else $error("compare set did not raise pin");
  wrap_tog_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE_18
    is_oc && wrap && ctl.tov && !cmp_ev && !ctl.maxd |=> pin_out != $past(pin_out))
    else $error("pin did not toggle on wrap");
endmodule

// ===== src/cct_timer.sv
// four-channel capture/compare timer with APB register slave
// How it works
// RULE_01 - 16-bit up counter, free or modulo
// RULE_02 - counter wraps at period limit value
// RULE_03 - counter reads never disturb counting
// RULE_04 - 3-bit field selects counter clock
// RULE_05 - four channels, each capture or compare
// RULE_06 - active edge copies counter into value
// RULE_07 - capture on rising, falling or both
// RULE_08 - capture and compare raise channel irq
// RULE_09 - compare match sets, clears, toggles pin
// RULE_10 - unbuffered value writes take effect immediately
// RULE_11 - lower value from compare handler
// RULE_12 - raise value from overflow handler
// RULE_13 - channel 0 buffer bit links 0,1
// RULE_14 - last written set takes over at wrap
// RULE_15 - linked odd channel control unused, pin released
// RULE_16 - channel 2 buffer bit links 2,3
// RULE_17 - software avoids writing active value set
// RULE_18 - toggle on wrap makes pwm period
// RULE_19 - pwm compare action opposes pulse level
// RULE_20 - period is limit plus one counts
// RULE_21 - pulse width equals compare value
// RULE_22 - software never toggles pwm on compare
// RULE_23 - overflow flag set on wrap to zero
// RULE_24 - channel flag set per event, gated irq
// RULE_25 - no toggle gives 0%, full duty 100%
// RULE_26 - select all ones uses external clock
// RULE_27 - codes 0..6 divide by 1..64
`timescale 1ns/1ps
module cct_timer #(
  parameter int unsigned AW = 8,               // apb address width
  parameter int unsigned CW = cct_pkg::CNT_W   // counter width
) (
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [AW-1:0] paddr,
  input  wire logic [31:0]   pwdata,
  output logic      [31:0]   prdata,
  output logic               pready,
  output logic               pslverr,
  input  wire logic          ext_clk_in,   // external_timer_clock_pin
  input  wire logic [3:0]    ch_in,        // channel pins, input side
  output logic      [3:0]    ch_out,       // channel pins, output side
  output logic      [3:0]    ch_oe,        // channel pins, drive enable
  output logic               ovf_irq,
  output logic      [3:0]    ch_irq
);
  localparam int unsigned NCH = cct_pkg::NCH;

  // bus state
  logic [31:0]  prdata_q;      // read data, captured in setup
  logic         pready_q;      // high during access cycle
  logic         pslverr_q;     // unmapped or misaligned
  logic [31:0]  rd_d;          // read mux
  logic         err_d;         // decode error
  logic         wr;            // write takes effect
  logic         is_ch;         // address in channel page
  logic [1:0]   idx;           // channel index from address
  logic [NCH-1:0] wr_ctl;      // channel control written
  logic [NCH-1:0] wr_val;      // channel value written
  logic         wr_sc;         // status/control written
  logic         cnt_rst;       // counter reset command

  // control and status
  logic            ovf_flag_q;  // overflow_flag
  logic            ovf_ie_q;    // overflow_irq_enable
  logic            stop_q;      // counter stopped
  logic [2:0]      sel_q;       // clock_select_field
  logic [CW-1:0]   mod_q;       // period_limit_high:low
  logic [CW-1:0]   cnt_q;       // counter
  logic [cct_pkg::DIV_W-1:0] div_q;  // prescaler
  logic            ext_prev_q;  // external clock last level
  cct_pkg::cct_chctl_s ctl_q [NCH];  // channel control
  logic [CW-1:0]   val_q [NCH];      // channel_value_high:low
  logic            ovf_irq_q;
  logic [NCH-1:0]  ch_irq_q;

  // buffered pairs: index 0 is pair 0/1, index 1 is pair 2/3
  logic [1:0]      link;        // pair linked
  logic [1:0]      wrote_odd_q; // last write went to odd channel
  logic [1:0]      act_odd_q;   // odd channel values in control

  // counter timing
  logic [6:0]      mask;        // divider mask for the select code
  logic            tick;        // selected counter clock enable
  logic            adv;         // counter steps this cycle
  logic            wrap;        // counter passes limit this cycle
  logic [CW-1:0]   cnt_nx;      // counter after this cycle

  // channel wiring
  cct_pkg::cct_chctl_s ctl_eff [NCH];
  logic [CW-1:0]   cmp_val [NCH];
  logic [NCH-1:0]  en;
  logic [NCH-1:0]  cap_ev;
  logic [NCH-1:0]  cmp_ev;
  logic [NCH-1:0]  ev;

  // ---------------- apb decode ----------------
  always_comb begin
    wr     = psel & penable & pwrite & pready_q;
    is_ch  = (paddr[7:5] == cct_pkg::CH_PAGE) && (paddr[1:0] == 2'h0);
    idx    = paddr[cct_pkg::CH_IDX_LSB +: 2];
    wr_sc  = wr && (paddr == cct_pkg::OFS_SC);
    cnt_rst = wr_sc & pwdata[cct_pkg::SC_RST];
    for (int i = 0; i < NCH; i++) begin
      wr_ctl[i] = wr & is_ch & ~paddr[cct_pkg::CH_VAL_BIT] & (idx == 2'(i));
      wr_val[i] = wr & is_ch & paddr[cct_pkg::CH_VAL_BIT] & (idx == 2'(i));
    end
  end

  // read mux; a counter read is a plain look, nothing is latched or held
  always_comb begin
    rd_d  = 32'h0000_0000;
    err_d = 1'h0;
    if (is_ch) begin
      rd_d = paddr[cct_pkg::CH_VAL_BIT] ? {16'h0000, val_q[idx]} : {24'h00_0000, ctl_q[idx]};
    end else begin
      case (paddr)
        cct_pkg::OFS_SC:  rd_d = {24'h00_0000, ovf_flag_q, ovf_ie_q, stop_q, 2'h0, sel_q};
        // RULE_03 read has no side effect
        cct_pkg::OFS_CNT: rd_d = {16'h0000, cnt_q};
        cct_pkg::OFS_MOD: rd_d = {16'h0000, mod_q};
        default:          err_d = 1'h1;
      endcase
    end
  end

  // bus answer: one wait-free access phase, data taken in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q  <= 32'h0000_0000;
      pready_q  <= 1'h0;
      pslverr_q <= 1'h0;
    end else begin
      pready_q <= psel & ~penable;
      if (psel && !penable) begin
        prdata_q  <= pwrite ? 32'h0000_0000 : rd_d;
        pslverr_q <= err_d;
      end else begin
        pslverr_q <= 1'h0;
      end
    end
  end

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;

  // ---------------- status and control ----------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovf_ie_q <= 1'h0;
      stop_q   <= cct_pkg::STOP_RST;
      sel_q    <= cct_pkg::SEL_RST;
      mod_q    <= cct_pkg::MOD_RST;
    end else begin
      if (wr_sc) begin
        ovf_ie_q <= pwdata[cct_pkg::SC_IE];
        stop_q   <= pwdata[cct_pkg::SC_STOP];
        // RULE_04 clock select write
        sel_q    <= pwdata[cct_pkg::SEL_MSB:0];
      end
      if (wr && paddr == cct_pkg::OFS_MOD) begin
        mod_q <= pwdata[CW-1:0];
      end
    end
  end

  // overflow flag: wrap beats a software clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovf_flag_q <= 1'h0;
    end else if (wrap) begin
      // RULE_23 flag on wrap
      ovf_flag_q <= 1'h1;
    end else if (wr_sc && !pwdata[cct_pkg::SC_FLAG]) begin
      ovf_flag_q <= 1'h0;
    end
  end

  // ---------------- prescaler and counter ----------------
  always_comb begin
    // RULE_27 binary divide ratios
    mask = 7'((7'h01 << sel_q) - 7'h01);
    // RULE_26 external pin when all ones
    if (sel_q == cct_pkg::SEL_EXT) begin
      tick = ext_clk_in & ~ext_prev_q;
    end else begin
      tick = (div_q & mask[cct_pkg::DIV_W-1:0]) == mask[cct_pkg::DIV_W-1:0];
    end
    adv  = tick & ~stop_q & ~cnt_rst;
    // RULE_02 wrap at period limit
    wrap = adv & (cnt_q == mod_q);
    // RULE_20 limit plus one counts
    cnt_nx = wrap ? '0 : CW'(cnt_q + 1'h1);
  end

  // divider runs free so a select change takes effect within one slow period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q      <= '0;
      ext_prev_q <= 1'h0;
    end else begin
      ext_prev_q <= ext_clk_in;
      div_q      <= cnt_rst ? '0 : cct_pkg::DIV_W'(div_q + 1'h1);
    end
  end

  // RULE_01 16-bit up counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= '0;
    end else if (cnt_rst) begin
      cnt_q <= '0;
    end else if (adv) begin
      cnt_q <= cnt_nx;
    end
  end

  // ---------------- buffered pairs ----------------
  always_comb begin
    // RULE_13 pair 0/1 link bit
    link[0] = ctl_q[0].buf_;
    // RULE_16 pair 2/3 link bit
    link[1] = ctl_q[2].buf_;
  end

  // track the last written set and hand it over only at wrap
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wrote_odd_q <= 2'h0;
      act_odd_q   <= 2'h0;
    end else begin
      for (int p = 0; p < 2; p++) begin
        if (!link[p]) begin
          wrote_odd_q[p] <= 1'h0;
          act_odd_q[p]   <= 1'h0;
        end else begin
          if (wr_val[2*p+1]) begin
            wrote_odd_q[p] <= 1'h1;
          end else if (wr_val[2*p]) begin
            wrote_odd_q[p] <= 1'h0;
          end
          // RULE_14 swap set at wrap
          if (wrap) begin
            act_odd_q[p] <= wrote_odd_q[p];
          end
        end
      end
    end
  end

  // effective control and compare value per channel
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      ctl_eff[i] = ctl_q[i];
      cmp_val[i] = val_q[i];
      en[i]      = 1'h1;
    end
    for (int p = 0; p < 2; p++) begin
      if (link[p]) begin
        // a linked even channel always compares
        ctl_eff[2*p].oc = 1'h1;
        cmp_val[2*p]    = act_odd_q[p] ? val_q[2*p+1] : val_q[2*p];
        // RULE_15 odd pin released
        en[2*p+1]       = 1'h0;
      end
    end
  end

  // ---------------- channel registers ----------------
  // RULE_05 four channels, each odd one released when its pair is linked
  for (genvar g = 0; g < NCH; g++) begin : g_ch
    cct_chan #(.CW(CW)) u_chan (
      .pclk    (pclk),
      .presetn (presetn),
      .ctl     (ctl_eff[g]),
      .en      (en[g]),
      .adv     (adv),
      .wrap    (wrap),
      .cnt_nx  (cnt_nx),
      .cmp_val (cmp_val[g]),
      .pin_in  (ch_in[g]),
      .cap_ev  (cap_ev[g]),
      .cmp_ev  (cmp_ev[g]),
      .pin_out (ch_out[g]),
      .pin_oe  (ch_oe[g])
    );
  end

  assign ev = cap_ev | cmp_ev;

  // channel control: an event beats a clear written in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NCH; i++) begin
        ctl_q[i] <= cct_pkg::CTL_RST;
      end
    end else begin
      for (int i = 0; i < NCH; i++) begin
        if (wr_ctl[i]) begin
          ctl_q[i] <= pwdata[7:0];
          // odd channels have no buffer bit
          ctl_q[i].buf_ <= (i % 2 == 0) ? pwdata[5] : 1'h0;
          ctl_q[i].flag <= ctl_q[i].flag & pwdata[cct_pkg::CH_FLAG];
        end
        // RULE_24 flag per event
        if (ev[i]) begin
          ctl_q[i].flag <= 1'h1;
        end
      end
    end
  end

  // channel values: capture beats a bus write in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NCH; i++) begin
        val_q[i] <= cct_pkg::VAL_RST;
      end
    end else begin
      for (int i = 0; i < NCH; i++) begin
        if (cap_ev[i]) begin
          // RULE_06 latch counter on edge
          val_q[i] <= cnt_q;
        end else if (wr_val[i]) begin
          // RULE_10 immediate value replace
          val_q[i] <= pwdata[CW-1:0];
        end
      end
    end
  end

  // ---------------- interrupt requests ----------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovf_irq_q <= 1'h0;
      ch_irq_q  <= '0;
    end else begin
      ovf_irq_q <= ovf_flag_q & ovf_ie_q;
      // RULE_08 irq per channel
      for (int i = 0; i < NCH; i++) begin
        ch_irq_q[i] <= ctl_q[i].flag & ctl_q[i].ie;
      end
    end
  end

  assign ovf_irq = ovf_irq_q;
  assign ch_irq  = ch_irq_q;

  // ---------------- checks ----------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  cnt_wrap_a: assert property (wrap |=> cnt_q == '0) // RULE_02
    else $error("counter did not wrap to zero");
  cnt_read_a: assert property (psel && !pwrite && !adv && !cnt_rst |=> $stable(cnt_q)) // RULE_03
    else $error("read disturbed counter");
  ovf_flag_a: assert property (wrap |=> ovf_flag_q ##1 (ovf_irq == $past(ovf_ie_q))) // RULE_23
    else $error("overflow flag or request missing");
  div_two_a: assert property (sel_q == 3'h1 && tick && !wr_sc |=> !tick) // RULE_27
    else $error("divide by two ticked twice");
  cap_load_a: assert property (cap_ev[1] |=> val_q[1] == $past(cnt_q)) // RULE_06
    else $error("capture did not load counter");
  ch_irq_a: assert property (ev[1] && ctl_q[1].ie |=> ctl_q[1].flag ##1 ch_irq[1]) // RULE_24
    else $error("channel request missing");
  buf_swap_a: assert property (link[1] && wrap |=> act_odd_q[1] == $past(wrote_odd_q[1])) // RULE_14
    else $error("buffer set not handed over");
  pin_rel_a: assert property (link[1] ##1 link[1] |-> !ch_oe[3]) // RULE_15
    else $error("linked odd pin still driven");
  stop_hold_a: assert property (stop_q && !cnt_rst |=> $stable(cnt_q)) // RULE_01
    else $error("stopped counter moved");

  cap_seen_c:  cover property (cap_ev[1]);
  wrap_seen_c: cover property (wrap && ch_oe[0]);
  swap_seen_c: cover property (link[1] && wrap && wrote_odd_q[1]);
endmodule

// ===== verif/cct_pins.sv
// pin-side model: event sources on channel inputs and the external clock source
`timescale 1ns/1ps
module cct_pins (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [3:0] ch_out,      // channel pin output levels
  input  wire logic [3:0] ch_oe,       // channel pin drive enables
  input  wire logic [3:0] drive,       // level the outside source puts on a released pin
  input  wire logic       ext_run,     // external clock runs only while high
  output logic      [3:0] ch_in,       // resolved pin levels
  output logic            ext_clk_in   // external_timer_clock_pin
);
  logic [1:0] div_q;  // external clock divider, rising edge every fourth pclk
  // a driven pin shows the block's level, a released pin the outside source
  assign ch_in = (ch_oe & ch_out) | (~ch_oe & drive);
  // clock stands still while not running, so no stray ticks reach the counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= 2'h0;
    end else if (ext_run) begin
      div_q <= div_q + 2'h1;
    end
  end
  assign ext_clk_in = div_q[1];
endmodule

// ===== verif/test_cct_timer.sv
// self-checking bench for the capture/compare timer
`timescale 1ns/1ps
module test_cct_timer;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, ovf_irq, ext_run;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [3:0]  ch_in, ch_out, ch_oe, ch_irq, drive;
  logic        ext_clk_in, rerr;
  int          num_errors, total_checks;
  cct_timer i_cct_timer (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ext_clk_in(ext_clk_in), .ch_in(ch_in), .ch_out(ch_out),
    .ch_oe(ch_oe), .ovf_irq(ovf_irq), .ch_irq(ch_irq));
  cct_pins i_cct_pins (.pclk(pclk), .presetn(presetn), .ch_out(ch_out), .ch_oe(ch_oe),
    .drive(drive), .ext_run(ext_run), .ch_in(ch_in), .ext_clk_in(ext_clk_in));
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  task automatic final_report();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic hang();
    num_errors++;
    final_report();
  endtask
  // one apb transfer; the request stands until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
      if (n > 50) hang();
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rdat, exp);
  endtask
  task automatic waitc(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // measure high time and period of a channel pin from one rising edge
  task automatic measure(input int ch, output int hi, output int per);
    int n;
    n = 0; hi = 0; per = 0;
    while (!(ch_out[ch] === 1'b0)) begin @(posedge pclk); n++; if (n > 5000) hang(); end
    while (!(ch_out[ch] === 1'b1)) begin @(posedge pclk); n++; if (n > 5000) hang(); end
    while (ch_out[ch] === 1'b1) begin @(posedge pclk); hi++; if (hi > 5000) hang(); end
    per = hi;
    while (!(ch_out[ch] === 1'b1)) begin @(posedge pclk); per++; if (per > 5000) hang(); end
  endtask
  task automatic t_reset_map();
    rdchk(8'h00, 32'h20);
    rdchk(8'h08, 32'hFFFF);
    for (int x = 0; x < 4; x++) begin
      rdchk(8'h20 + 8'(8 * x), 32'h0);
      rdchk(8'h24 + 8'(8 * x), 32'h0);
    end
    chk(ch_oe, 4'h0);
    rdchk(8'h10, 32'h0);
    chk(rerr, 1'b1);
    apb(1'b1, 8'h09, 32'h5);
    chk(rerr, 1'b1);
    rdchk(8'h08, 32'hFFFF);
  endtask
  // live counter reads, equally spaced transfers see equally spaced counts
  task automatic t_count_read();
    logic [31:0] c1;
    apb(1'b1, 8'h00, 32'h10);
    apb(1'b0, 8'h04, 32'h0);
    c1 = rdat;
    apb(1'b0, 8'h04, 32'h0);
    chk(rdat - c1, 32'h3);
  endtask
  // pwm on channel 0 for every clock select code, plus the 8-bit example
  task automatic t_pwm_select();
    int hi, per, d;
    for (int s = -1; s < 8; s++) begin
      d = (s == 7) ? 4 : (s < 0) ? 1 : (1 << s);
      ext_run <= (s == 7);
      apb(1'b1, 8'h00, 32'h30);
      apb(1'b1, 8'h08, (s < 0) ? 32'hFF : 32'hF);
      apb(1'b1, 8'h24, (s < 0) ? 32'h80 : 32'(s + 1));
      apb(1'b1, 8'h20, 32'h5A);
      apb(1'b1, 8'h00, 32'h50 | 32'((s < 0) ? 0 : s));
      measure(0, hi, per);
      chk(per, ((s < 0) ? 256 : 16) * d);
      chk(hi, ((s < 0) ? 128 : s + 1) * d);
      chk(ch_irq[0], 1'b1);
      rdchk(8'h20, 32'hDA);
      chk(ovf_irq, 1'b1);
    end
    ext_run <= 1'b0;
  endtask
  // overflow flag clear and masking
  task automatic t_overflow();
    apb(1'b1, 8'h00, 32'h20);
    waitc(3);
    chk(ovf_irq, 1'b0);
    apb(1'b1, 8'h08, 32'hF);
    apb(1'b1, 8'h00, 32'h10);
    waitc(40);
    rdchk(8'h00, 32'h80);
    chk(ovf_irq, 1'b0);
  endtask
  // compare actions without wrap toggling, and full duty
  task automatic t_actions();
    int hi, per, bad;
    logic [7:0] ctl [3] = '{8'h14, 8'h19, 8'h18};
    for (int k = 0; k < 3; k++) begin
      apb(1'b1, 8'h24, 32'h8);
      apb(1'b1, 8'h20, 32'(ctl[k]));
      if (k == 0) begin
        measure(0, hi, per);
        chk(hi, 16);
        chk(per, 32);
      end else begin
        bad = 0;
        waitc(40);
        repeat (32) begin @(posedge pclk); if (ch_out[0] !== (k == 1)) bad++; end
        chk(bad, 0);
      end
    end
  endtask
  // linked pair 2/3: last written set takes control at the wrap
  task automatic t_buffered();
    int hi, per;
    apb(1'b1, 8'h34, 32'h4);
    apb(1'b1, 8'h30, 32'h3A);
    measure(2, hi, per);
    chk(hi, 4);
    chk(ch_oe[3], 1'b0);
    chk(ch_oe[2], 1'b1);
    apb(1'b1, 8'h3C, 32'hA);
    measure(2, hi, per);
    measure(2, hi, per);
    chk(hi, 10);
    apb(1'b1, 8'h34, 32'h6);
    measure(2, hi, per);
    measure(2, hi, per);
    chk(hi, 6);
    chk(per, 16);
    apb(1'b1, 8'h34, 32'h2);
    chk(ch_out[2], 1'b1);
    waitc(20);
    measure(2, hi, per);
    chk(hi, 2);
  endtask
  // unbuffered width changes written at the safe points of the period
  task automatic t_sync_update();
    int hi, per, n;
    apb(1'b1, 8'h08, 32'h1F);
    apb(1'b1, 8'h24, 32'h8);
    apb(1'b1, 8'h20, 32'h5A);
    measure(0, hi, per);
    apb(1'b1, 8'h24, 32'hC);
    measure(0, hi, per);
    chk(hi, 12);
    n = 0;
    while (ch_out[0] !== 1'b0) begin @(posedge pclk); n++; if (n > 100) hang(); end
    apb(1'b1, 8'h24, 32'h4);
    measure(0, hi, per);
    chk(hi, 4);
    chk(per, 32);
  endtask
  // capture on each edge mode with a frozen counter
  task automatic t_capture();
    logic [31:0] c;
    logic        hit;
    apb(1'b1, 8'h00, 32'h20);
    apb(1'b0, 8'h04, 32'h0);
    c = rdat;
    for (int el = 1; el < 4; el++) begin
      for (int e = 0; e < 2; e++) begin
        hit = (e == 0) ? el[0] : el[1];
        drive[1] <= e[0];
        waitc(4);
        apb(1'b1, 8'h28, 32'h40 | 32'(el << 2));
        apb(1'b1, 8'h2C, 32'h1234);
        drive[1] <= ~e[0];
        waitc(4);
        rdchk(8'h2C, hit ? c : 32'h1234);
        rdchk(8'h28, {hit, 7'h40 | 7'(el << 2)});
        chk(ch_irq[1], hit);
      end
    end
  endtask
  initial begin
    num_errors = 0;
    total_checks = 0;
    presetn = 1'b0;
    psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h0; pwdata = 32'h0;
    drive = 4'h0; ext_run = 1'b0;
    waitc(20);
    presetn <= 1'b1;
    t_reset_map();
    t_count_read();
    t_pwm_select();
    t_overflow();
    t_actions();
    t_buffered();
    t_sync_update();
    t_capture();
    final_report();
  end
endmodule
